/* File: rtl/exec_slice_pkg.sv */
// Shared constants and carrier types for the move and halfword multiply slice
package exec_slice_pkg;

    // Data widths
    localparam int unsigned XLEN = 32;
    localparam int unsigned NUM_W = 10;
    localparam int unsigned MASK_W = 8;
    localparam int unsigned GROUP_W = 4;

    // Condition register result field, big-endian bits 0:3
    localparam int unsigned CR0_LT_BIT = 31;
    localparam int unsigned CR0_GT_BIT = 30;
    localparam int unsigned CR0_EQ_BIT = 29;
    localparam int unsigned CR0_SO_BIT = 28;
    localparam int unsigned CR0_LSB = 28;

    // Time base register numbers and their encoded field values
    localparam logic [NUM_W-1:0] TB_LOW_NUM = 10'h10C;
    localparam logic [NUM_W-1:0] TB_HIGH_NUM = 10'h10D;
    localparam logic [NUM_W-1:0] TB_LOW_FIELD = 10'h188;
    localparam logic [NUM_W-1:0] TB_HIGH_FIELD = 10'h1A8;

    // Field bit that marks a privileged special register (instruction bit 11)
    localparam int unsigned SPEC_PRIV_BIT = 9;
    // Machine state bit that marks user state
    localparam int unsigned MSR_USER_BIT = 14;

    // Register port map
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_COND = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_MSTATE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_TB_LOW = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_TB_HIGH = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h14;

    // Field positions and reset values
    localparam int unsigned CTRL_TB_EN_BIT = 0;
    localparam int unsigned STAT_PRIV_BIT = 0;
    localparam int unsigned STAT_ILL_BIT = 1;
    localparam logic [XLEN-1:0] COND_RESET = 32'h0000_0000;
    localparam logic [XLEN-1:0] MSTATE_RESET = 32'h0000_0000;
    localparam logic [XLEN-1:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [63:0] TB_RESET = 64'h0000_0000_0000_0000;

    // Operations accepted on the issue port
    typedef enum logic [3:0] {
        OP_NONE,
        OP_MOVE_COND_FIELDS,
        OP_MOVE_ALL_COND,
        OP_MOVE_DEVCTL,
        OP_MOVE_MACHSTATE,
        OP_MOVE_SPECIAL,
        OP_READ_TB_LOW,
        OP_READ_TB_UPPER,
        OP_READ_TB_NUM,
        OP_MUL_CROSS,
        OP_MUL_HIGH,
        OP_MUL_LOW,
        OP_MUL_HIGH_WORD
    } op_type;

    typedef enum logic {
        ST_RUN,
        ST_SYNC
    } sync_state_type;

    typedef struct packed {
        logic              valid;
        op_type            op;
        logic [MASK_W-1:0] field_mask;
        logic [NUM_W-1:0]  num_field;
        logic              record_flag;
        logic              bit31;
        logic              unsigned_flag;
        logic [4:0]        dest_idx;
        logic [XLEN-1:0]   value_gpr;
        logic [XLEN-1:0]   multiplicand_gpr;
        logic [XLEN-1:0]   multiplier_gpr;
    } issue_type;

    typedef struct packed {
        logic            valid;
        logic            gpr_we;
        logic [4:0]      dest_idx;
        logic [XLEN-1:0] dest_gpr;
        logic            priv_fault;
        logic            illegal;
    } retire_type;

    typedef struct packed {
        logic             we;
        logic [NUM_W-1:0] num;
        logic [XLEN-1:0]  data;
    } side_wr_type;

endpackage

/* File: rtl/hw_mul_unit.sv */
// Halfword and high-word multiplier shared by all multiply operations
`timescale 1ns/1ns
module hw_mul_unit
    import exec_slice_pkg::*;
(
    // Operation select
    input  wire op_type          op,
    input  wire logic            unsigned_flag,
    // Operands
    input  wire logic [XLEN-1:0] multiplicand_gpr,
    input  wire logic [XLEN-1:0] multiplier_gpr,
    // Result
    output logic      [XLEN-1:0] product
);

    logic [15:0]        half_a;
    logic [15:0]        half_b;
    logic signed [16:0] ext_a;
    logic signed [16:0] ext_b;
    logic signed [33:0] half_prod;
    logic [63:0]        word_prod;

    // Halfword pick; big-endian 16:31 is the low half
    assign half_a = (op == OP_MUL_HIGH) ? multiplicand_gpr[31:16] : multiplicand_gpr[15:0];
    assign half_b = (op == OP_MUL_LOW) ? multiplier_gpr[15:0] : multiplier_gpr[31:16];

    // One 17x17 signed multiplier serves both signed and unsigned forms
    assign ext_a = {(~unsigned_flag & half_a[15]), half_a};
    assign ext_b = {(~unsigned_flag & half_b[15]), half_b};
    assign half_prod = ext_a * ext_b;

    // Full unsigned word product, upper word kept
    assign word_prod = multiplicand_gpr * multiplier_gpr;
    assign product = (op == OP_MUL_HIGH_WORD) ? word_prod[63:32] : half_prod[31:0];

endmodule

/* File: rtl/cond_field_calc.sv */
// Result condition field: less, greater, equal and summary overflow
`timescale 1ns/1ns
module cond_field_calc
    import exec_slice_pkg::*;
(
    // Result and current summary overflow
    input  wire logic [XLEN-1:0] result,
    input  wire logic            so_in,
    // Field in big-endian order LT, GT, EQ, SO
    output logic      [3:0]      field
);

    logic is_zero;

    // Compared as signed against zero
    assign is_zero = (result == 32'h0000_0000);
    assign field = {result[XLEN-1], ~result[XLEN-1] & ~is_zero, is_zero, so_in};

endmodule

/* File: rtl/exec_move_mul.sv */
// Execution unit for condition, control-register moves, time base reads and multiplies
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ns
module exec_move_mul
    import exec_slice_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Issue port
    input  wire issue_type         issue_in,
    input  wire logic              older_busy,
    output logic                   issue_ready,
    // Retire port
    output retire_type             retire_out,
    // Control register write ports
    output side_wr_type            devctl_wr,
    output side_wr_type            spec_wr,
    // Fixed-point summary overflow, read only
    input  wire logic              so_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [XLEN-1:0]   reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [XLEN-1:0]   reg_rdata,
    // Architectural state view
    output logic      [XLEN-1:0]   cond_reg,
    output logic      [XLEN-1:0]   machine_state_reg
);

    // Swap the two 5-bit halves of an encoded register number
    function automatic logic [NUM_W-1:0] swap_num(input logic [NUM_W-1:0] f);
        swap_num = {f[4:0], f[9:5]};
    endfunction

    // Widen each mask bit to a 4-bit group; mask bit 0 is the rightmost group, bits 3:0
    function automatic logic [XLEN-1:0] expand_mask(input logic [MASK_W-1:0] m);
        logic [XLEN-1:0] r;
        r = '0;
        for (int k = 0; k < MASK_W; k++)
        begin
            r[k*GROUP_W +: GROUP_W] = {GROUP_W{m[k]}};
        end
        expand_mask = r;
    endfunction

    sync_state_type  state_ff;
    sync_state_type  nxt_state;
    logic [XLEN-1:0] cond_ff;
    logic [XLEN-1:0] nxt_cond;
    logic [XLEN-1:0] mstate_ff;
    logic [XLEN-1:0] ctrl_ff;
    logic [63:0]     tb_ff;
    logic [63:0]     nxt_tb;
    logic [1:0]      status_ff;
    logic [1:0]      nxt_status;
    retire_type      retire_ff;
    side_wr_type     devctl_ff;
    side_wr_type     spec_ff;
    logic [XLEN-1:0] rdata_ff;

    logic            take;
    logic            user_state;
    logic            priv_op;
    logic            priv_fault;
    logic            illegal;
    logic            exec_ok;
    logic            is_mul;
    logic            is_tb;
    logic            is_cond_move;
    logic [NUM_W-1:0] reg_num;
    logic            tb_sel_high;
    logic [XLEN-1:0] product;
    logic [3:0]      rec_field;
    logic [XLEN-1:0] cond_mask;
    logic [XLEN-1:0] moved_cond;
    logic [XLEN-1:0] recorded_cond;
    logic [XLEN-1:0] dest_value;
    logic            sync_hold;
    logic            wr_cond;
    logic            wr_ctrl;
    logic            wr_tb_low;
    logic            wr_tb_high;
    logic            wr_status;
    logic [XLEN-1:0] read_mux;

    // Operation classes
    assign is_mul = (issue_in.op == OP_MUL_CROSS) | (issue_in.op == OP_MUL_HIGH)
                  | (issue_in.op == OP_MUL_LOW) | (issue_in.op == OP_MUL_HIGH_WORD);
    assign is_tb = (issue_in.op == OP_READ_TB_LOW) | (issue_in.op == OP_READ_TB_UPPER)
                 | (issue_in.op == OP_READ_TB_NUM);
    assign is_cond_move = (issue_in.op == OP_MOVE_COND_FIELDS) | (issue_in.op == OP_MOVE_ALL_COND);

    // Machine-state move must not start while older work is in flight
    assign sync_hold = issue_in.valid & (issue_in.op == OP_MOVE_MACHSTATE) & older_busy;
    assign issue_ready = (state_ff == ST_RUN) & ~sync_hold;
    assign take = issue_in.valid & issue_ready;

    // Privilege check against the current machine state
    assign user_state = mstate_ff[MSR_USER_BIT];
    assign priv_op = (issue_in.op == OP_MOVE_DEVCTL)
                   | (issue_in.op == OP_MOVE_MACHSTATE)
                   | ((issue_in.op == OP_MOVE_SPECIAL) & issue_in.num_field[SPEC_PRIV_BIT]);
    assign priv_fault = take & priv_op & user_state;

    // Register number decode shared by device-control, special and time base forms
    assign reg_num = swap_num(issue_in.num_field);
    assign tb_sel_high = (issue_in.op == OP_READ_TB_UPPER)
                       | ((issue_in.op == OP_READ_TB_NUM) & (reg_num == TB_HIGH_NUM));
    assign illegal = take & (issue_in.op == OP_READ_TB_NUM)
                   & (reg_num != TB_LOW_NUM) & (reg_num != TB_HIGH_NUM);
    assign exec_ok = take & ~priv_fault & ~illegal & (issue_in.op != OP_NONE);

    hw_mul_unit u_mul (
        .op               (issue_in.op),
        .unsigned_flag    (issue_in.unsigned_flag),
        .multiplicand_gpr (issue_in.multiplicand_gpr),
        .multiplier_gpr   (issue_in.multiplier_gpr),
        .product          (product)
    );

    // Summary overflow only read here; no overflow state is ever written
    cond_field_calc u_cond (
        .result (product),
        .so_in  (so_in),
        .field  (rec_field)
    );

    // Masked field move; move-all forces every group
    assign cond_mask = expand_mask((issue_in.op == OP_MOVE_ALL_COND) ? 8'hFF : issue_in.field_mask);
    assign moved_cond = (issue_in.value_gpr & cond_mask) | (cond_ff & ~cond_mask);
    assign recorded_cond = {rec_field, cond_ff[CR0_LSB-1:0]};

    // Condition register update; an instruction beats a port write in the same cycle.
    // Bit 31 on a move is ignored; the mask alone decides which groups are written, the result field included.
    assign wr_cond = reg_wr & (reg_addr == ADDR_COND);
    assign nxt_cond = (exec_ok & is_cond_move) ? moved_cond
                    : (exec_ok & is_mul & issue_in.record_flag) ? recorded_cond
                    : wr_cond ? reg_wdata
                    : cond_ff;

    // Result for the destination register
    assign dest_value = is_mul ? product
                      : tb_sel_high ? tb_ff[63:32]
                      : tb_ff[31:0];

    // Time base counts every cycle while enabled; a port write reloads one word
    assign wr_tb_low = reg_wr & (reg_addr == ADDR_TB_LOW);
    assign wr_tb_high = reg_wr & (reg_addr == ADDR_TB_HIGH);
    assign nxt_tb = wr_tb_low ? {tb_ff[63:32], reg_wdata}
                  : wr_tb_high ? {reg_wdata, tb_ff[31:0]}
                  : ctrl_ff[CTRL_TB_EN_BIT] ? tb_ff + 64'h0000_0000_0000_0001
                  : tb_ff;

    // Sticky fault flags; a new fault wins over a write-one clear
    assign wr_ctrl = reg_wr & (reg_addr == ADDR_CTRL);
    assign wr_status = reg_wr & (reg_addr == ADDR_STATUS);
    assign nxt_status[STAT_PRIV_BIT] = priv_fault
                                     | (status_ff[STAT_PRIV_BIT] & ~(wr_status & reg_wdata[STAT_PRIV_BIT]));
    assign nxt_status[STAT_ILL_BIT] = illegal
                                    | (status_ff[STAT_ILL_BIT] & ~(wr_status & reg_wdata[STAT_ILL_BIT]));

    // Read data, unmapped addresses return zero
    assign read_mux = (reg_addr == ADDR_COND) ? cond_ff
                    : (reg_addr == ADDR_MSTATE) ? mstate_ff
                    : (reg_addr == ADDR_TB_LOW) ? tb_ff[31:0]
                    : (reg_addr == ADDR_TB_HIGH) ? tb_ff[63:32]
                    : (reg_addr == ADDR_STATUS) ? {30'h0000_0000, status_ff}
                    : (reg_addr == ADDR_CTRL) ? ctrl_ff
                    : 32'h0000_0000;

    // One stall cycle after a machine-state move so the next instruction sees it
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN:
            begin
                if (exec_ok & (issue_in.op == OP_MOVE_MACHSTATE))
                begin
                    nxt_state = ST_SYNC;
                end
            end
            ST_SYNC:
            begin
                nxt_state = ST_RUN;
            end
            default:
            begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // Architectural state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff  <= ST_RUN;
            cond_ff   <= COND_RESET;
            mstate_ff <= MSTATE_RESET;
            ctrl_ff   <= CTRL_RESET;
            tb_ff     <= TB_RESET;
            status_ff <= 2'h0;
        end
        else
        begin
            state_ff  <= nxt_state;
            cond_ff   <= nxt_cond;
            tb_ff     <= nxt_tb;
            status_ff <= nxt_status;
            if (exec_ok & (issue_in.op == OP_MOVE_MACHSTATE))
            begin
                mstate_ff <= issue_in.value_gpr;
            end
            if (wr_ctrl)
            begin
                ctrl_ff <= reg_wdata;
            end
        end
    end

    // Retire record, one cycle after issue
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            retire_ff <= '0;
        end
        else
        begin
            retire_ff.valid      <= take;
            retire_ff.gpr_we     <= exec_ok & (is_mul | is_tb);
            retire_ff.dest_idx   <= issue_in.dest_idx;
            retire_ff.dest_gpr   <= dest_value;
            retire_ff.priv_fault <= priv_fault;
            retire_ff.illegal    <= illegal;
        end
    end

    // Device-control and special register writes; faults suppress them
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            devctl_ff <= '0;
            spec_ff   <= '0;
        end
        else
        begin
            devctl_ff.we   <= exec_ok & (issue_in.op == OP_MOVE_DEVCTL);
            devctl_ff.num  <= reg_num;
            devctl_ff.data <= issue_in.value_gpr;
            spec_ff.we     <= exec_ok & (issue_in.op == OP_MOVE_SPECIAL);
            spec_ff.num    <= reg_num;
            spec_ff.data   <= issue_in.value_gpr;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            rdata_ff <= reg_rd ? read_mux : 32'h0000_0000;
        end
    end

    assign retire_out = retire_ff;
    assign devctl_wr = devctl_ff;
    assign spec_wr = spec_ff;
    assign reg_rdata = rdata_ff;
    assign cond_reg = cond_ff;
    assign machine_state_reg = mstate_ff;

endmodule

/* File: dv/exec_move_mul_sva.sv */
// Checker for the move and halfword multiply slice
`timescale 1ns/1ns
module exec_move_mul_chk
    import exec_slice_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Issue and retire
    input wire issue_type         issue_in,
    input wire logic              older_busy,
    input wire logic              issue_ready,
    input wire retire_type        retire_out,
    // Control writes and summary overflow
    input wire side_wr_type       devctl_wr,
    input wire side_wr_type       spec_wr,
    input wire logic              so_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [XLEN-1:0]   reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [XLEN-1:0]   reg_rdata,
    // State view
    input wire logic [XLEN-1:0]   cond_reg,
    input wire logic [XLEN-1:0]   machine_state_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Take, privilege and reference product
    wire            take = issue_in.valid && issue_ready;
    wire            user = machine_state_reg[MSR_USER_BIT];
    wire [63:0]     wide = {32'h0, issue_in.multiplicand_gpr} * {32'h0, issue_in.multiplier_gpr};
    wire            is_mul = issue_in.op inside {OP_MUL_CROSS, OP_MUL_HIGH, OP_MUL_LOW, OP_MUL_HIGH_WORD};
    wire [XLEN-1:0] mask;

    // Field mask widened to 4-bit groups
    for (genvar g = 0; g < 8; g++)
    begin : grp
        assign mask[4*g+:4] = {4{issue_in.field_mask[g]}};
    end

    // Machine-state move: update, then one stalled cycle
    sequence mst_take;
        take && issue_in.op == OP_MOVE_MACHSTATE && !user;
    endsequence
    sequence mst_done;
        machine_state_reg == $past(issue_in.value_gpr) && !issue_ready ##1 issue_ready;
    endsequence

    retire_pulse_a: assert property (1 |=> retire_out.valid == $past(take))
        else $error("retire pulse not tied to a take");
    devctl_swap_a: assert property (take && issue_in.op == OP_MOVE_DEVCTL && !user |=> devctl_wr.we
        && devctl_wr.num == {$past(issue_in.num_field[4:0]), $past(issue_in.num_field[9:5])}
        && devctl_wr.data == $past(issue_in.value_gpr)) else $error("device control write wrong");
    devctl_priv_a: assert property (take && issue_in.op == OP_MOVE_DEVCTL && user |=>
        !devctl_wr.we && retire_out.priv_fault && !retire_out.gpr_we) else $error("user device write");
    mst_sync_a: assert property (mst_take |=> mst_done)
        else $error("machine state move not synchronizing");
    mst_wait_a: assert property (issue_in.valid && issue_in.op == OP_MOVE_MACHSTATE && older_busy |->
        !issue_ready) else $error("machine state move taken while older busy");
    cond_mask_a: assert property (take && issue_in.op == OP_MOVE_COND_FIELDS && !issue_in.bit31 |=>
        cond_reg == (($past(issue_in.value_gpr) & $past(mask)) | ($past(cond_reg) & ~$past(mask))))
        else $error("field move result wrong");
    cr0_keep_a: assert property (take && is_mul && !issue_in.record_flag && !reg_wr |=>
        $stable(cond_reg)) else $error("unrecorded multiply changed condition");
    mul_word_a: assert property (take && issue_in.op == OP_MUL_HIGH_WORD |=>
        retire_out.dest_gpr == $past(wide[63:32])) else $error("high word product wrong");
endmodule

bind exec_move_mul exec_move_mul_chk i_exec_move_mul_chk (.clk_sys, .rst_n, .issue_in, .older_busy,
    .issue_ready, .retire_out, .devctl_wr, .spec_wr, .so_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cond_reg, .machine_state_reg);

/* File: dv/exec_move_mul_test.sv */
// Self-checking bench for the move and halfword multiply slice
`timescale 1ns/1ns
module exec_move_mul_test
    import exec_slice_pkg::*;
;
    // Design inputs, all set at time zero
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    issue_type         issue_in = '0;
    logic              older_busy = 1'b0;
    logic              so_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [XLEN-1:0]   reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    // Design outputs and captured results
    logic              issue_ready;
    retire_type        retire_out;
    retire_type        ret;
    side_wr_type       devctl_wr;
    side_wr_type       spec_wr;
    side_wr_type       dcw;
    side_wr_type       spw;
    logic [XLEN-1:0]   reg_rdata;
    logic [XLEN-1:0]   cond_reg;
    logic [XLEN-1:0]   machine_state_reg;
    logic [XLEN-1:0]   xc;
    int                n_errors = 0;
    int                samples_checked = 0;

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    exec_move_mul i_exec_move_mul (.clk_sys, .rst_n, .issue_in, .older_busy, .issue_ready, .retire_out,
        .devctl_wr, .spec_wr, .so_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cond_reg,
        .machine_state_reg);

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Issue one op, wait for the take, capture the retire cycle
    task automatic issue(input op_type op, input logic [31:0] a, input logic [31:0] b,
                         input logic [9:0] num, input logic [7:0] msk, input logic [3:0] flg);
        issue_type it;
        it = '{1'b1, op, msk, num, flg[0], flg[2], flg[1], 5'h15, a, a, b};
        @(posedge clk_sys);
        issue_in <= it;
        so_in <= flg[3];
        for (int t = 0; t < 50; t++)
        begin
            @(negedge clk_sys);
            if (issue_ready === 1'b1)
                break;
        end
        @(posedge clk_sys);
        issue_in.valid <= 1'b0;
        @(negedge clk_sys);
        ret = retire_out;
        dcw = devctl_wr;
        spw = spec_wr;
        chk("retire valid", 32'h1, {31'h0, ret.valid});
    endtask

    task automatic rw(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rr(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // Reference product, worked from operand halves, or from the full words for the high-word form
    function automatic logic [31:0] mexp(op_type op, logic u, logic [31:0] a, logic [31:0] b);
        logic [15:0] x;
        logic [15:0] y;
        logic [63:0] w;
        x = (op == OP_MUL_HIGH) ? a[31:16] : a[15:0];
        y = (op == OP_MUL_LOW) ? b[15:0] : b[31:16];
        w = {32'h0, a} * {32'h0, b};
        if (op == OP_MUL_HIGH_WORD)
            return w[63:32];
        if (u)
            return {16'h0, x} * {16'h0, y};
        return $signed(x) * $signed(y);
    endfunction

    // Time base frozen so reads are predictable; port map corners too
    task automatic t_tb();
        logic [31:0] d;
        rr(ADDR_CTRL, d);
        chk("ctrl reset", CTRL_RESET, d);
        rw(ADDR_CTRL, 32'h0);
        rw(ADDR_TB_LOW, 32'h1357_9BDF);
        rw(ADDR_TB_HIGH, 32'h2468_ACE0);
        rw(ADDR_MSTATE, 32'hFFFF_FFFF);
        rr(ADDR_MSTATE, d);
        chk("state read only", 32'h0, d);
        rr(8'hFC, d);
        chk("unmapped", 32'h0, d);
        issue(OP_READ_TB_LOW, '0, '0, '0, '0, 4'h0);
        chk("tb low", 32'h1357_9BDF, ret.dest_gpr);
        issue(OP_READ_TB_UPPER, '0, '0, '0, '0, 4'h0);
        chk("tb high", 32'h2468_ACE0, ret.dest_gpr);
        issue(OP_READ_TB_NUM, '0, '0, 10'h188, '0, 4'h0);
        chk("tb num low", 32'h1357_9BDF, ret.dest_gpr);
        issue(OP_READ_TB_NUM, '0, '0, 10'h1A8, '0, 4'h0);
        chk("tb num high", 32'h2468_ACE0, ret.dest_gpr);
        issue(OP_READ_TB_NUM, '0, '0, 10'h10C, '0, 4'h0);
        chk("tb bad num", 32'h2, {30'h0, ret.illegal, ret.gpr_we});
    endtask

    // Field moves, mask table hits single, scattered and no groups; move-all covers every group
    task automatic t_cond();
        logic [7:0] m[4] = '{8'h01, 8'h80, 8'h5A, 8'h00};
        logic [31:0] v;
        logic [31:0] e;
        rw(ADDR_COND, 32'hA5A5_5A5A);
        xc = 32'hA5A5_5A5A;
        v = 32'h1234_5678;
        foreach (m[i])
        begin
            issue(OP_MOVE_COND_FIELDS, v, '0, '0, m[i], 4'h0);
            for (int g = 0; g < 8; g++)
                e[4*g+:4] = {4{m[i][g]}};
            xc = (v & e) | (xc & ~e);
            chk("cond fields", xc, cond_reg);
            v = ~v;
        end
        issue(OP_MOVE_ALL_COND, v, '0, '0, 8'h00, 4'h0);
        chk("cond all", v, cond_reg);
        issue(OP_MOVE_COND_FIELDS, ~v, '0, '0, 8'h01, 4'h4);
        xc = {v[31:4], ~v[3:0]};
        chk("cond bit31", xc & 32'h0FFF_FFFF, cond_reg & 32'h0FFF_FFFF);
        // Result field is undefined here, so only its nibble is taken over
        xc = {cond_reg[31:28], v[27:4], ~v[3:0]};
    endtask

    // Every multiply form, signed and unsigned, recorded or not
    task automatic t_mul();
        op_type ops[4] = '{OP_MUL_CROSS, OP_MUL_HIGH, OP_MUL_LOW, OP_MUL_HIGH_WORD};
        logic [31:0] a[3] = '{32'h8001_FFFF, 32'h7FFF_0003, 32'h0000_0000};
        logic [31:0] b[3] = '{32'hFFFE_7FFF, 32'h8000_FFFD, 32'h1234_5678};
        logic [31:0] r;
        foreach (ops[k])
            for (int u = 0; u < 2; u++)
                foreach (a[j])
                begin
                    r = mexp(ops[k], u[0], a[j], b[j]);
                    issue(ops[k], a[j], b[j], '0, '0, {j[1], 1'b0, u[0], j != 1});
                    chk("product", r, ret.dest_gpr);
                    chk("dest", 32'h35, {26'h0, ret.gpr_we, ret.dest_idx});
                    if (j != 1)
                        xc[31:28] = {$signed(r) < 0, $signed(r) > 0, r == 0, j[1]};
                    chk("cond record", xc, cond_reg);
                end
    endtask

    // Supervisor control writes carry the swapped number
    task automatic t_ctl();
        issue(OP_MOVE_DEVCTL, 32'hDEAD_0001, '0, 10'h188, '0, 4'h0);
        chk("dcr num", {21'h0, 1'b1, 10'h10C}, {21'h0, dcw.we, dcw.num});
        chk("dcr data", 32'hDEAD_0001, dcw.data);
        issue(OP_MOVE_SPECIAL, 32'h0BAD_F00D, '0, 10'h3E1, '0, 4'h0);
        chk("spr num", {21'h0, 1'b1, 10'h03F}, {21'h0, spw.we, spw.num});
        chk("spr data", 32'h0BAD_F00D, spw.data);
    endtask

    // Synchronizing move into user state, then privilege checks
    task automatic t_user();
        logic [31:0] d;
        fork
            issue(OP_MOVE_MACHSTATE, 32'h0000_4000, '0, '0, '0, 4'h0);
            begin
                @(posedge clk_sys);
                older_busy <= 1'b1;
                repeat (3)
                begin
                    @(negedge clk_sys);
                    chk("ready while busy", 32'h0, {31'h0, issue_ready});
                end
                @(posedge clk_sys);
                older_busy <= 1'b0;
            end
        join
        chk("state", 32'h0000_4000, machine_state_reg);
        chk("stall", 32'h0, {31'h0, issue_ready});
        @(negedge clk_sys);
        chk("resume", 32'h1, {31'h0, issue_ready});
        issue(OP_MOVE_DEVCTL, 32'h1, '0, 10'h188, '0, 4'h0);
        chk("dcr user", 32'h2, {29'h0, dcw.we, ret.priv_fault, ret.gpr_we});
        issue(OP_MOVE_SPECIAL, 32'h2, '0, 10'h3E1, '0, 4'h0);
        chk("spr priv user", 32'h2, {29'h0, spw.we, ret.priv_fault, ret.gpr_we});
        issue(OP_MOVE_SPECIAL, 32'h3, '0, 10'h1E1, '0, 4'h0);
        chk("spr open user", {20'h0, 2'b10, 10'h02F}, {20'h0, spw.we, ret.priv_fault, spw.num});
        issue(OP_MOVE_MACHSTATE, 32'h0, '0, '0, '0, 4'h0);
        chk("state user", 32'h0000_4001, {machine_state_reg[31:1], ret.priv_fault});
        rr(ADDR_STATUS, d);
        chk("sticky faults", 32'h3, d);
        rw(ADDR_STATUS, 32'h3);
        rr(ADDR_STATUS, d);
        chk("faults cleared", 32'h0, d);
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_tb();
        t_cond();
        t_mul();
        t_ctl();
        t_user();
        end_sim();
    end
endmodule
